// ==== logic/guard_host_pkg.sv ====
// Constants and types of the flash protection command host
package guard_host_pkg;
   // APB register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_PWD0   = 8'h10;
   localparam logic [7:0] REG_PWD3   = 8'h1c;
   // Timing at 10 MHz
   localparam int CLK_NS          = 100;
   localparam int UNLOCK_GAP_NS   = 1000;
   localparam int GAP_CYC         = (UNLOCK_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] GAP_CNT = 4'(GAP_CYC);
   localparam logic [2:0] WE_CYC  = 3'h2;
   localparam logic [2:0] RD_CYC  = 3'h4;
   // Command codes and unlock addresses
   localparam logic [22:0] ADR_555 = 23'h000555;
   localparam logic [22:0] ADR_2AA = 23'h0002aa;
   localparam logic [22:0] ADR_0   = 23'h000000;
   localparam logic [15:0] D_AA = 16'h00aa;
   localparam logic [15:0] D_55 = 16'h0055;
   localparam logic [15:0] D_A0 = 16'h00a0;
   localparam logic [15:0] D_90 = 16'h0090;
   localparam logic [15:0] D_00 = 16'h0000;
   localparam logic [15:0] D_80 = 16'h0080;
   localparam logic [15:0] D_30 = 16'h0030;
   localparam logic [15:0] D_25 = 16'h0025;
   localparam logic [15:0] D_03 = 16'h0003;
   localparam logic [15:0] D_29 = 16'h0029;

   typedef enum logic [3:0] {
      OP_ENT_EXT, OP_EXIT_EXT, OP_ENT_LREG, OP_ENT_PWD, OP_ENT_PERSISTENT_BLOCK_GUARD_BIT,
      OP_ENT_LBIT, OP_ENT_VPB, OP_EXIT_PROT, OP_PROG, OP_READ,
      OP_CLR_ALL, OP_UNLOCK, OP_PWD_PROG4, OP_PWD_RD4
   } op_t;

   typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_SETUP, ST_STROBE, ST_RECOV} state_t;

   // One bus cycle of a command sequence
   typedef struct packed {
      logic        last;
      logic        rd;
      logic [22:0] addr;
      logic [15:0] data;
   } step_t;

   // Flash pin drive
   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        dq_oe_n;
      logic [22:0] addr;
      logic [15:0] dq;
   } pins_t;

   localparam pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 23'h0, 16'h0};
endpackage : guard_host_pkg

// ==== logic/guard_host.sv ====
// Flash protection command host with APB control registers
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module guard_host
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output var  logic        o_pready,
   output var  logic [31:0] o_prdata,
   output var  logic        o_pslverr,
   output var  logic [22:0] o_addr,
   output var  logic [15:0] o_dq_out,
   output var  logic        o_dq_oe_n,
   input  wire logic [15:0] i_dq_in,
   output var  logic        o_ce_n,
   output var  logic        o_oe_n,
   output var  logic        o_we_n
);
   // --------------------------------------------------
   // Sequence table
   // --------------------------------------------------
   function automatic guard_host_pkg::step_t step_of(
      input guard_host_pkg::op_t op, input logic [2:0] i,
      input logic [22:0] a, input logic [15:0] d, input logic [15:0] pw);
      guard_host_pkg::step_t s;
      logic [22:0] u;
      s = '{1'b0, 1'b0, guard_host_pkg::ADR_0, guard_host_pkg::D_00};
      u = (i == 3'h1) ? guard_host_pkg::ADR_2AA : guard_host_pkg::ADR_555;
      case (op)
         // Three-write entry preambles
         guard_host_pkg::OP_ENT_EXT, guard_host_pkg::OP_ENT_LREG,
         guard_host_pkg::OP_ENT_PWD, guard_host_pkg::OP_ENT_PERSISTENT_BLOCK_GUARD_BIT,
         guard_host_pkg::OP_ENT_LBIT, guard_host_pkg::OP_ENT_VPB:
         begin
            s.addr = u;
            s.last = (i == 3'h2);
            s.data = (i == 3'h0) ? guard_host_pkg::D_AA : guard_host_pkg::D_55;
            if (i == 3'h2)
            begin
               case (op)
                  guard_host_pkg::OP_ENT_EXT:  s.data = 16'h0088;
                  guard_host_pkg::OP_ENT_LREG: s.data = 16'h0040;
                  guard_host_pkg::OP_ENT_PWD:  s.data = 16'h0060;
                  guard_host_pkg::OP_ENT_PERSISTENT_BLOCK_GUARD_BIT: s.data = 16'h00c0;
                  guard_host_pkg::OP_ENT_LBIT: s.data = 16'h0050;
                  default:                     s.data = 16'h00e0;
               endcase
            end
         end
         guard_host_pkg::OP_EXIT_EXT:
         begin
            s.addr = (i == 3'h3) ? guard_host_pkg::ADR_0 : u;
            s.data = (i == 3'h0) ? guard_host_pkg::D_AA : (i == 3'h1) ? guard_host_pkg::D_55 :
                     (i == 3'h2) ? guard_host_pkg::D_90 : guard_host_pkg::D_00;
            s.last = (i == 3'h3);
         end
         guard_host_pkg::OP_EXIT_PROT:
         begin
            s.data = (i == 3'h0) ? guard_host_pkg::D_90 : guard_host_pkg::D_00;
            s.last = (i == 3'h1);
         end
         guard_host_pkg::OP_PROG:
         begin
            s.addr = (i == 3'h0) ? guard_host_pkg::ADR_0 : a;
            s.data = (i == 3'h0) ? guard_host_pkg::D_A0 : d;
            s.last = (i == 3'h1);
         end
         guard_host_pkg::OP_READ:
         begin
            s.addr = a;
            s.rd   = 1'b1;
            s.last = 1'b1;
         end
         guard_host_pkg::OP_CLR_ALL:
         begin
            s.data = (i == 3'h0) ? guard_host_pkg::D_80 : guard_host_pkg::D_30;
            s.last = (i == 3'h1);
         end
         guard_host_pkg::OP_UNLOCK:
         begin
            // 00/25, 00/03, four password words, 00/29
            s.addr = (i >= 3'h2 && i <= 3'h5) ? {21'h0, 2'(i - 3'h2)} : guard_host_pkg::ADR_0;
            s.data = (i == 3'h0) ? guard_host_pkg::D_25 : (i == 3'h1) ? guard_host_pkg::D_03 :
                     (i == 3'h6) ? guard_host_pkg::D_29 : pw;
            s.last = (i == 3'h6);
         end
         guard_host_pkg::OP_PWD_PROG4:
         begin
            s.addr = i[0] ? {21'h0, i[2:1]} : guard_host_pkg::ADR_0;
            s.data = i[0] ? pw : guard_host_pkg::D_A0;
            s.last = (i == 3'h7);
         end
         guard_host_pkg::OP_PWD_RD4:
         begin
            s.addr = {21'h0, i[1:0]};
            s.rd   = 1'b1;
            s.last = (i == 3'h3);
         end
         default:
         begin
            s.last = 1'b1;
         end
      endcase
      return s;
   endfunction : step_of

   // Word index of the password word used by the current step
   function automatic logic [1:0] pw_sel(input guard_host_pkg::op_t op, input logic [2:0] i);
      logic [2:0] k;
      k = i - 3'h2;
      return (op == guard_host_pkg::OP_UNLOCK) ? k[1:0] :
             (op == guard_host_pkg::OP_PWD_PROG4) ? i[2:1] : i[1:0];
   endfunction : pw_sel

   // --------------------------------------------------
   // State
   // --------------------------------------------------
   guard_host_pkg::state_t st_q, st_d;
   guard_host_pkg::op_t    op_q, op_d;
   guard_host_pkg::pins_t  pins_q, pins_d;
   guard_host_pkg::step_t  cur;
   logic [2:0]  idx_q, idx_d, cnt_q, cnt_d;
   logic [3:0]  gap_q, gap_d;
   logic [22:0] addr_q, addr_d;
   logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [15:0] pwd_q [4];
   logic [15:0] pwd_d [4];
   logic        pready_q, pready_d, slverr_q, slverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [15:0] dq_s1_q, dq_s2_q, dq_s3_q;
   logic        acc, wr;

   // Three-stage pin synchroniser; stage 1 feeds stage 2 only
   always_ff @(posedge i_sys_clk)
   begin
      dq_s1_q <= i_dq_in;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
   end

   assign cur = step_of(op_q, idx_q, addr_q, wdata_q, pwd_q[pw_sel(op_q, idx_q)]);
   assign acc = i_psel && i_penable && !pready_q;
   assign wr  = acc && i_pwrite;

   // Next-state logic for APB registers and the bus-cycle engine
   always_comb
   begin
      st_d     = st_q;
      op_d     = op_q;
      idx_d    = idx_q;
      cnt_d    = cnt_q;
      gap_d    = (gap_q < guard_host_pkg::GAP_CNT) ? gap_q + 4'h1 : gap_q;
      pins_d   = pins_q;
      addr_d   = addr_q;
      wdata_d  = wdata_q;
      rdata_d  = rdata_q;
      pwd_d    = pwd_q;
      pready_d = acc;
      slverr_d = 1'b0;
      prdata_d = 32'h0;
      // Slave decode; one wait state per access
      if (acc)
      begin
         if (i_paddr == guard_host_pkg::REG_CTRL)
         begin
            if (i_pwrite && st_q == guard_host_pkg::ST_IDLE && i_pwdata[3:0] <= 4'hd)
            begin
               op_d  = guard_host_pkg::op_t'(i_pwdata[3:0]);
               idx_d = 3'h0;
               st_d  = guard_host_pkg::ST_GAP;
            end
            prdata_d = {28'h0, op_q};
         end
         else if (i_paddr == guard_host_pkg::REG_ADDR)
         begin
            if (i_pwrite)
               addr_d = i_pwdata[22:0];
            prdata_d = {9'h0, addr_q};
         end
         else if (i_paddr == guard_host_pkg::REG_WDATA)
         begin
            if (i_pwrite)
               wdata_d = i_pwdata[15:0];
            prdata_d = {16'h0, wdata_q};
         end
         else if (i_paddr == guard_host_pkg::REG_STATUS)
            prdata_d = {rdata_q, 15'h0, (st_q != guard_host_pkg::ST_IDLE)};
         else if (i_paddr >= guard_host_pkg::REG_PWD0 && i_paddr <= guard_host_pkg::REG_PWD3
                  && i_paddr[1:0] == 2'h0)
         begin
            if (i_pwrite && st_q == guard_host_pkg::ST_IDLE)
               pwd_d[i_paddr[3:2]] = i_pwdata[15:0];
            prdata_d = {16'h0, pwd_q[i_paddr[3:2]]};
         end
         else
            slverr_d = 1'b1;
      end
      // Engine: setup, strobe, recovery per bus cycle
      case (st_q)
         guard_host_pkg::ST_IDLE:
            pins_d = guard_host_pkg::PINS_IDLE;
         guard_host_pkg::ST_GAP:
         begin
            // Back-to-back unlocks wait out the spacing
            if (op_q != guard_host_pkg::OP_UNLOCK || gap_q >= guard_host_pkg::GAP_CNT)
            begin
               st_d = guard_host_pkg::ST_SETUP;
               pins_d.ce_n = 1'b0;
               pins_d.addr = cur.addr;
               pins_d.dq = cur.data;
               pins_d.dq_oe_n = cur.rd;
            end
         end
         guard_host_pkg::ST_SETUP:
         begin
            st_d = guard_host_pkg::ST_STROBE;
            cnt_d = cur.rd ? guard_host_pkg::RD_CYC : guard_host_pkg::WE_CYC;
            pins_d.we_n = cur.rd;
            pins_d.oe_n = !cur.rd;
         end
         guard_host_pkg::ST_STROBE:
         begin
            if (cnt_q != 3'h1)
               cnt_d = cnt_q - 3'h1;
            else if (!cur.rd || dq_s2_q == dq_s3_q)
            begin
               // Read data settles through the synchroniser first
               if (cur.rd && op_q == guard_host_pkg::OP_PWD_RD4)
                  pwd_d[idx_q[1:0]] = dq_s3_q;
               else if (cur.rd)
                  rdata_d = dq_s3_q;
               st_d = guard_host_pkg::ST_RECOV;
               // Only strobes rise; data holds through the latching edge
               pins_d.we_n = 1'b1;
               pins_d.oe_n = 1'b1;
               if (op_q == guard_host_pkg::OP_UNLOCK && cur.last)
                  gap_d = 4'h0;
            end
         end
         guard_host_pkg::ST_RECOV:
         begin
            // Release the bus a cycle after the strobe ends
            pins_d = guard_host_pkg::PINS_IDLE;
            pins_d.addr = pins_q.addr;
            idx_d = idx_q + 3'h1;
            st_d = cur.last ? guard_host_pkg::ST_IDLE : guard_host_pkg::ST_GAP;
         end
         default:
            st_d = guard_host_pkg::ST_IDLE;
      endcase
   end

   // Register stage
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         st_q     <= guard_host_pkg::ST_IDLE;
         op_q     <= guard_host_pkg::OP_READ;
         idx_q    <= 3'h0;
         cnt_q    <= 3'h0;
         gap_q    <= guard_host_pkg::GAP_CNT;
         pins_q   <= guard_host_pkg::PINS_IDLE;
         addr_q   <= 23'h0;
         wdata_q  <= 16'h0;
         rdata_q  <= 16'h0;
         pwd_q    <= '{16'hffff, 16'hffff, 16'hffff, 16'hffff};
         pready_q <= 1'b0;
         slverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end
      else
      begin
         st_q     <= st_d;
         op_q     <= op_d;
         idx_q    <= idx_d;
         cnt_q    <= cnt_d;
         gap_q    <= gap_d;
         pins_q   <= pins_d;
         addr_q   <= addr_d;
         wdata_q  <= wdata_d;
         rdata_q  <= rdata_d;
         pwd_q    <= pwd_d;
         pready_q <= pready_d;
         slverr_q <= slverr_d;
         prdata_q <= prdata_d;
      end
   end

   assign o_pready  = pready_q;
   assign o_prdata  = prdata_q;
   assign o_pslverr = slverr_q;
   assign o_addr    = pins_q.addr;
   assign o_dq_out  = pins_q.dq;
   assign o_dq_oe_n = pins_q.dq_oe_n;
   assign o_ce_n    = pins_q.ce_n;
   assign o_oe_n    = pins_q.oe_n;
   assign o_we_n    = pins_q.we_n;

   // --------------------------------------------------
   // Checks
   // --------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   logic done;
   assign done = st_q == guard_host_pkg::ST_RECOV && cur.last;
   sequence s_wpulse;
      (!o_we_n && !o_ce_n && !o_dq_oe_n)[*2] ##1 o_we_n;
   endsequence
   property p_we_pulse;
      $fell(o_we_n) |-> s_wpulse;
   endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("write strobe malformed");
   property p_no_fight;
      !(!o_oe_n && !o_dq_oe_n);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("read while driving dq");
   property p_ent3;
      done && op_q == guard_host_pkg::OP_ENT_EXT |-> idx_q == 3'h2 && $past(o_dq_out) == 16'h0088;
   endproperty
   a_ent3: assert property (p_ent3) else $error("extended entry length wrong");
   property p_exit4;
      done && op_q == guard_host_pkg::OP_EXIT_EXT |-> idx_q == 3'h3;
   endproperty
   a_exit4: assert property (p_exit4) else $error("extended exit length wrong");
   property p_lreg3;
      done && op_q == guard_host_pkg::OP_ENT_LREG |-> idx_q == 3'h2 && $past(o_dq_out) == 16'h0040;
   endproperty
   a_lreg3: assert property (p_lreg3) else $error("lock entry wrong");
   property p_exitp;
      done && op_q == guard_host_pkg::OP_EXIT_PROT |-> idx_q == 3'h1 && $past(o_dq_out) == 16'h0000;
   endproperty
   a_exitp: assert property (p_exitp) else $error("protection exit wrong");
   property p_pwsel;
      st_q == guard_host_pkg::ST_STROBE && op_q == guard_host_pkg::OP_PWD_PROG4 && idx_q[0]
         |-> o_addr[1:0] == idx_q[2:1];
   endproperty
   a_pwsel: assert property (p_pwsel) else $error("password word select wrong");
   property p_pwrd;
      st_q == guard_host_pkg::ST_STROBE && op_q == guard_host_pkg::OP_PWD_RD4
         |-> !o_oe_n && o_addr[1:0] == idx_q[1:0];
   endproperty
   a_pwrd: assert property (p_pwrd) else $error("password read address wrong");
   property p_gap;
      st_q == guard_host_pkg::ST_GAP && st_d == guard_host_pkg::ST_SETUP
         && op_q == guard_host_pkg::OP_UNLOCK && idx_q == 3'h0 |-> gap_q >= guard_host_pkg::GAP_CNT;
   endproperty
   a_gap: assert property (p_gap) else $error("unlock spacing violated");
   property p_apb;
      i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer timing wrong");
endmodule : guard_host
`default_nettype wire

// ==== dv/flash_model.sv ====
// Behavioural flash device that answers the protection command sets
`timescale 1ns/1ps
`default_nettype none
module flash_model
(
   input  wire logic        i_ce_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic [22:0] i_addr,
   input  wire logic [15:0] i_dq,
   output var  logic [15:0] o_dq,
   output var  logic [7:0]  o_unlocks,
   output var  logic [7:0]  o_gap_err
);
   logic [15:0] ext [0:255];
   logic [15:0] pwd [0:3];
   logic [15:0] last = 16'h0;
   logic [1:0]  mode = 2'h0; // 0 read, 1 extended, 2 password, 3 other set
   logic [1:0]  ul   = 2'h0;
   logic [2:0]  uc   = 3'h0;
   logic        pend = 1'b0;
   logic        ex0  = 1'b0;
   logic        ok   = 1'b0;
   logic [22:0] a    = 23'h0;
   realtime     t_un = -1.0e6;
   // --------------------------------------------------------------
   // Power-up contents
   // --------------------------------------------------------------
   initial
   begin
      o_unlocks = 8'h0;
      o_gap_err = 8'h0;
      foreach (ext[i]) ext[i] = 16'hffff;
      foreach (pwd[i]) pwd[i] = 16'hffff;
   end
   // Address is latched on the falling write strobe
   always @(negedge i_we_n) a = i_addr;
   // Command decode at the rising write strobe
   always @(posedge i_we_n)
   begin
      if (uc != 3'h0)
      begin
         uc = uc + 3'h1;
         if (uc > 3'h2 && uc < 3'h7 && i_dq !== pwd[a[1:0]]) ok = 1'b0;
         if (uc == 3'h7)
         begin
            if (ok) o_unlocks = o_unlocks + 8'h1;
            uc = 3'h0;
            t_un = $realtime;
         end
      end
      else if (pend)
      begin
         pend = 1'b0;
         // Lower half is factory-locked, upper half takes programming
         if (mode == 2'h1 && a[7]) ext[a[7:0]] = ext[a[7:0]] & i_dq;
         if (mode == 2'h2) pwd[a[1:0]] = i_dq;
      end
      else if (ex0)
      begin
         ex0 = 1'b0;
         if (i_dq[7:0] == 8'h00) mode = 2'h0;
      end
      else if (ul == 2'h2 && a[11:0] == 12'h555)
      begin
         ul = 2'h0;
         case (i_dq[7:0])
            8'h88: mode = 2'h1;
            8'h90: ex0 = (mode == 2'h1);
            8'h60: mode = 2'h2;
            default: mode = 2'h3;
         endcase
      end
      else if (ul == 2'h1 && a[11:0] == 12'h2aa && i_dq[7:0] == 8'h55) ul = 2'h2;
      else if (a[11:0] == 12'h555 && i_dq[7:0] == 8'haa) ul = 2'h1;
      else if (mode != 2'h0 && i_dq[7:0] == 8'ha0) pend = 1'b1;
      else if (mode[1] && i_dq[7:0] == 8'h90) ex0 = 1'b1;
      else if (mode == 2'h2 && i_dq[7:0] == 8'h25)
      begin
         // A too early unlock is dropped, not queued
         if ($realtime - t_un < 1000.0) o_gap_err = o_gap_err + 8'h1;
         else {uc, ok} = {3'h1, 1'b1};
      end
      else ul = 2'h0;
   end
   // Read drive; a released bus shows the inverse of the last word
   always @(i_ce_n, i_oe_n, i_addr, mode)
   begin
      if (!i_ce_n && !i_oe_n)
      begin
         if (mode == 2'h1 && i_addr[22:8] == 15'h0) o_dq = ext[i_addr[7:0]];
         else if (mode == 2'h2) o_dq = pwd[i_addr[1:0]];
         else o_dq = i_addr[15:0] ^ 16'h5a5a;
         last = o_dq;
      end
      else o_dq = ~last;
   end
endmodule : flash_model
`default_nettype wire

// ==== dv/flash_block_protection_commands_bench.sv ====
// Self-checking bench of the flash protection command host
`timescale 1ns/1ps
`default_nettype none
module flash_block_protection_commands_bench;
   typedef struct packed {
      guard_host_pkg::op_t op;
      logic [22:0]         a;
      logic [15:0]         d;
      logic                chk;
      logic [15:0]         exp;
   } row_t;
   logic        sys_clk = 1'b0;
   logic        reset   = 1'b1;
   logic        psel    = 1'b0;
   logic        pen     = 1'b0;
   logic        pwr     = 1'b0;
   logic [7:0]  paddr   = 8'h0;
   logic [31:0] pwdata  = 32'h0;
   logic        pready, pslverr, dq_oe_n, ce_n, oe_n, we_n, er;
   logic [31:0] prdata, rd;
   logic [22:0] faddr;
   logic [15:0] dq_out, mdq, dq;
   logic [7:0]  unlocks, gap_err;
   int          fails = 0;
   int          compares = 0;
   row_t        rows [0:8];
   always #50 sys_clk = ~sys_clk;
   // Shared data line: host wins while it enables its driver
   assign dq = !dq_oe_n ? dq_out : mdq;
   guard_host dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .o_addr(faddr), .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .i_dq_in(dq),
      .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n));
   flash_model model (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(faddr), .i_dq(dq),
      .o_dq(mdq), .o_unlocks(unlocks), .o_gap_err(gap_err));
   // --------------------------------------------------------------
   // Bus and check tasks
   // --------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge sys_clk);
      {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
      @(posedge sys_clk);
      pen <= 1'b1;
      // Hold the request until pready is seen; only the watchdog ends a hang
      do
      begin
         @(posedge sys_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk
   // Start one engine operation and poll busy with a bounded count
   task automatic start(input guard_host_pkg::op_t op);
      apb(1'b1, guard_host_pkg::REG_CTRL, {28'h0, op});
      repeat (200)
      begin
         apb(1'b0, guard_host_pkg::REG_STATUS, 32'h0);
         if (rd[0] === 1'b0) break;
      end
      // A poll limit that runs out counts as a mismatch
      chk("engine idle", 32'h0, {31'h0, rd[0]});
   endtask : start
   task automatic run(input guard_host_pkg::op_t op, input logic [22:0] ad, input logic [15:0] wd);
      apb(1'b1, guard_host_pkg::REG_ADDR, {9'h0, ad});
      apb(1'b1, guard_host_pkg::REG_WDATA, {16'h0, wd});
      start(op);
   endtask : run
   task end_of_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial
   begin
      rows[0] = '{guard_host_pkg::OP_ENT_EXT, 23'h0, 16'h0, 1'b0, 16'h0};
      rows[1] = '{guard_host_pkg::OP_PROG, 23'h90, 16'h1234, 1'b0, 16'h0};
      rows[2] = '{guard_host_pkg::OP_READ, 23'h90, 16'h0, 1'b1, 16'h1234};
      rows[3] = '{guard_host_pkg::OP_PROG, 23'h90, 16'hffff, 1'b0, 16'h0};
      rows[4] = '{guard_host_pkg::OP_READ, 23'h90, 16'h0, 1'b1, 16'h1234};
      rows[5] = '{guard_host_pkg::OP_PROG, 23'h10, 16'h1234, 1'b0, 16'h0};
      rows[6] = '{guard_host_pkg::OP_READ, 23'h10, 16'h0, 1'b1, 16'hffff};
      rows[7] = '{guard_host_pkg::OP_EXIT_EXT, 23'h0, 16'h0, 1'b0, 16'h0};
      rows[8] = '{guard_host_pkg::OP_READ, 23'h90, 16'h0, 1'b1, 16'h5aca};
      repeat (2) @(posedge sys_clk);
      chk("ce_n in reset", 32'h1, {31'h0, ce_n});
      chk("we_n in reset", 32'h1, {31'h0, we_n});
      reset <= 1'b0;
      apb(1'b0, guard_host_pkg::REG_STATUS, 32'h0);
      chk("status after reset", 32'h0, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped slverr", 32'h1, {31'h0, er});
      foreach (rows[i])
      begin
         run(rows[i].op, rows[i].a, rows[i].d);
         if (rows[i].chk) chk("read word", {rows[i].exp, 16'h0}, {rd[31:16], 16'h0});
      end
      // Blank password, then program, scrub and read back
      run(guard_host_pkg::OP_ENT_PWD, 23'h0, 16'h0);
      run(guard_host_pkg::OP_PWD_RD4, 23'h0, 16'h0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, guard_host_pkg::REG_PWD0 + 8'(4 * i), 32'h0);
         chk("blank password", 32'hffff, rd);
         apb(1'b1, guard_host_pkg::REG_PWD0 + 8'(4 * i), 32'h1230 + 32'(i));
      end
      run(guard_host_pkg::OP_PWD_PROG4, 23'h0, 16'h0);
      for (int i = 0; i < 4; i++) apb(1'b1, guard_host_pkg::REG_PWD0 + 8'(4 * i), 32'h0);
      run(guard_host_pkg::OP_PWD_RD4, 23'h0, 16'h0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, guard_host_pkg::REG_PWD0 + 8'(4 * i), 32'h0);
         chk("password word", 32'h1230 + 32'(i), rd);
      end
      // Back-to-back unlocks must both be spaced and accepted
      run(guard_host_pkg::OP_UNLOCK, 23'h0, 16'h0);
      // Control write only, so the second start lands inside the spacing
      start(guard_host_pkg::OP_UNLOCK);
      chk("unlocks taken", 32'h2, {24'h0, unlocks});
      chk("early unlocks", 32'h0, {24'h0, gap_err});
      run(guard_host_pkg::OP_EXIT_PROT, 23'h0, 16'h0);
      run(guard_host_pkg::OP_READ, 23'h20, 16'h0);
      chk("read after exit", 32'h5a7a, {16'h0, rd[31:16]});
      // Reset in mid-strobe must drop the strobes and the busy flag
      apb(1'b1, guard_host_pkg::REG_CTRL, {28'h0, guard_host_pkg::OP_CLR_ALL});
      repeat (1) @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("we_n in mid reset", 32'h1, {31'h0, we_n});
      chk("ce_n in mid reset", 32'h1, {31'h0, ce_n});
      reset <= 1'b0;
      apb(1'b0, guard_host_pkg::REG_STATUS, 32'h0);
      chk("status after mid reset", 32'h0, rd);
      end_of_test();
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      #5000000;
      fails++;
      end_of_test();
   end
endmodule : flash_block_protection_commands_bench
`default_nettype wire
